//--- rtl/pek_gpio8.sv
`timescale 1ns/1ps
module pek_gpio8
  import pek_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [7:0] pin_i,
  input  wire logic [7:0] data_r,
  input  wire logic [7:0] dir_r,
  output logic [7:0]      rd_val,
  output logic [7:0]      pin_sync
);
  logic [7:0] s1_r;
  logic [7:0] s2_r;
  logic [7:0] s3_r;
  logic [7:0] stable_r;

  // Three-stage input synchroniser
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      stable_r <= 8'h00;
    else
      stable_r <= (s2_r & s3_r) | (stable_r & (s2_r | s3_r));
  end

  assign pin_sync = stable_r;
  // Read source by direction: pin when input, latch when output
  assign rd_val   = (dir_r & data_r) | (~dir_r & stable_r);
endmodule

//--- rtl/pek_pkg.sv
package pek_pkg;

  // Register offsets (byte addresses on the plain port)
  localparam logic [7:0] PEK_OFF_PORT_E_DATA      = 8'h08;
  localparam logic [7:0] PEK_OFF_PORT_E_DIRECTION = 8'h09;
  localparam logic [7:0] PEK_OFF_PORT_K_DATA      = 8'h32;
  localparam logic [7:0] PEK_OFF_PORT_K_DIRECTION = 8'h33;
  localparam logic [7:0] PEK_OFF_PULLUP_CONTROL   = 8'h0C;
  localparam logic [7:0] PEK_OFF_MODE_CONTROL     = 8'h0B;
  localparam logic [7:0] PEK_OFF_BUS_IF_CONTROL   = 8'h0E;

  // Field positions
  localparam int PEK_PULLUP_CONTROL_PORT_K_PULLUP_ENABLE_BIT = 7;
  localparam int PEK_PULLUP_CONTROL_PUPEE_BIT = 4;
  localparam int PEK_MODE_EMK_BIT   = 3;
  localparam int PEK_MODE_EME_BIT   = 2;
  localparam int PEK_EBI_CLOCK_STRETCH_SELECT_BIT   = 0;
  localparam int PEK_IRQ_PIN_BIT    = 1;
  localparam int PEK_NONMASKABLE_INTERRUPT_PIN_PIN_BIT   = 0;
  localparam int PEK_CS_EMU_BIT     = 7;
  localparam int PEK_CS_EXT_BIT     = 6;

  // Reset values
  localparam logic [7:0] PEK_RST_DATA      = 8'h00;
  localparam logic [7:0] PEK_RST_DIRECTION = 8'h00;
  localparam logic [7:0] PEK_RST_PULLUP    = 8'h90;
  localparam logic [7:0] PEK_RST_MODE      = 8'h00;
  localparam logic [7:0] PEK_RST_EBI       = 8'h01;

  // Port E bits that may drive; bits 1:0 never drive
  localparam logic [7:0] PEK_E_OUT_MASK = 8'hFC;

  // Chip-select quarter-cycle gap, in mclk cycles
  localparam int PEK_MCLK_HZ       = 40_000_000;
  localparam int PEK_GAP_CYCLES    = 1;

  // Chip mode
  typedef enum logic [1:0] {
    PEK_MODE_SINGLE     = 2'h0,
    PEK_MODE_EXPANDED   = 2'h1,
    PEK_MODE_PERIPHERAL = 2'h2
  } pek_chip_mode_e;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pek_req_s;

  // One 8-bit GPIO pin group
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } pek_pins_s;

  // External bus cycle info from the bus controller
  typedef struct packed {
    logic       clk_fall;
    logic       stretched;
    logic       emu_sel;
    logic       ext_sel;
    logic [5:0] page;
  } pek_xbus_s;

endpackage

//--- rtl/pek_port_ek.sv
`timescale 1ns/1ps
module pek_port_ek
  import pek_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           arst_n,
  input  pek_pkg::pek_req_s   req,
  output logic [7:0]          rdata,
  output logic                ext_echo,
  input  pek_pkg::pek_chip_mode_e chip_mode,
  input  pek_pkg::pek_xbus_s  xbus,
  input  wire logic [7:0]     port_e_pin_i,
  output pek_pkg::pek_pins_s  port_e_pins,
  input  wire logic [7:0]     port_k_pin_i,
  output pek_pkg::pek_pins_s  port_k_pins
);
  import pek_pkg::*;

  logic [7:0] port_e_data_r;
  logic [7:0] port_e_direction_r;
  logic [7:0] port_k_data_r;
  logic [7:0] port_k_direction_r;
  logic [7:0] pullup_control_r;
  logic [7:0] mode_control_r;
  logic [7:0] bus_interface_control_r;
  logic [7:0] rdata_r;
  logic       ext_echo_r;
  logic [7:0] e_rd;
  logic [7:0] k_rd;
  logic       in_exp;
  logic       in_per;
  logic       e_dir_mapped;
  logic       k_data_mapped;
  logic       port_k_emulation_enable;
  logic       port_e_emulation_enable;
  logic       clock_stretch_select;
  logic       hit;
  logic [7:0] rd_mux;
  logic       gap_r;
  logic [7:0] k_emu_o;
  logic       sel_wr;
  logic       sel_rd;
  logic       we_e_data;
  logic       we_e_dir;
  logic       we_k_data;
  logic       we_k_dir;
  logic       we_pullup;
  logic       we_mode;
  logic       we_bus_if;

  assign in_exp = (chip_mode == PEK_MODE_EXPANDED);
  assign in_per = (chip_mode == PEK_MODE_PERIPHERAL);
  assign port_k_emulation_enable    = mode_control_r[PEK_MODE_EMK_BIT];
  assign port_e_emulation_enable    = mode_control_r[PEK_MODE_EME_BIT];
  assign clock_stretch_select   = bus_interface_control_r[PEK_EBI_CLOCK_STRETCH_SELECT_BIT];

  // Map visibility; a hidden register is echoed on the external bus
  always_comb
  begin
    e_dir_mapped  = 1'b1;
    k_data_mapped = 1'b1;
    if (in_exp || in_per)
      e_dir_mapped = 1'b0;
    if (in_exp && port_e_emulation_enable)
      e_dir_mapped = 1'b0;
    if ((in_exp || in_per) && port_k_emulation_enable)
      k_data_mapped = 1'b0;
  end

  // Address decode
  always_comb
  begin
    hit = 1'b1;
    unique case (req.addr)
      PEK_OFF_PORT_E_DATA:      hit = 1'b1;
      PEK_OFF_PORT_E_DIRECTION: hit = e_dir_mapped;
      PEK_OFF_PORT_K_DATA:      hit = k_data_mapped;
      PEK_OFF_PORT_K_DIRECTION: hit = 1'b1;
      PEK_OFF_PULLUP_CONTROL:   hit = 1'b1;
      PEK_OFF_MODE_CONTROL:     hit = 1'b1;
      PEK_OFF_BUS_IF_CONTROL:   hit = 1'b1;
      default:                  hit = 1'b0;
    endcase
  end

  assign sel_wr = req.wr && hit;
  assign sel_rd = req.rd && hit;

  // Per-register write enables; hidden registers ignore writes
  always_comb
  begin
    we_e_data = sel_wr && (req.addr == PEK_OFF_PORT_E_DATA);
    we_e_dir  = sel_wr && (req.addr == PEK_OFF_PORT_E_DIRECTION);
    we_k_data = sel_wr && (req.addr == PEK_OFF_PORT_K_DATA);
    we_k_dir  = sel_wr && (req.addr == PEK_OFF_PORT_K_DIRECTION);
    we_pullup = sel_wr && (req.addr == PEK_OFF_PULLUP_CONTROL);
    we_mode   = sel_wr && (req.addr == PEK_OFF_MODE_CONTROL);
    we_bus_if = sel_wr && (req.addr == PEK_OFF_BUS_IF_CONTROL);
  end

  // Port E data latch
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      port_e_data_r <= PEK_RST_DATA;
    else if (we_e_data)
      port_e_data_r <= req.wdata;
  end

  // Port E direction; interrupt bits can never become outputs
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      port_e_direction_r <= PEK_RST_DIRECTION;
    else if (we_e_dir)
      port_e_direction_r <= req.wdata & PEK_E_OUT_MASK;
  end

  // Port K data latch
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      port_k_data_r <= PEK_RST_DATA;
    else if (we_k_data)
      port_k_data_r <= req.wdata;
  end

  // Port K direction
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      port_k_direction_r <= PEK_RST_DIRECTION;
    else if (we_k_dir)
      port_k_direction_r <= req.wdata;
  end

  // Pull-up control
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pullup_control_r <= PEK_RST_PULLUP;
    else if (we_pullup)
      pullup_control_r <= req.wdata;
  end

  // Emulation mode control
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      mode_control_r <= PEK_RST_MODE;
    else if (we_mode)
      mode_control_r <= req.wdata;
  end

  // Bus interface control
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      bus_interface_control_r <= PEK_RST_EBI;
    else if (we_bus_if)
      bus_interface_control_r <= req.wdata;
  end

  // Pin synchronisers and read source selection
  pek_gpio8 u_port_e (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .pin_i    (port_e_pin_i),
    .data_r   (port_e_data_r),
    .dir_r    (port_e_direction_r),
    .rd_val   (e_rd),
    .pin_sync ()
  );

  pek_gpio8 u_port_k (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .pin_i    (port_k_pin_i),
    .data_r   (port_k_data_r),
    .dir_r    (port_k_direction_r),
    .rd_val   (k_rd),
    .pin_sync ()
  );

  // Read mux
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (req.addr)
      PEK_OFF_PORT_E_DATA:      rd_mux = e_rd;
      PEK_OFF_PORT_E_DIRECTION: rd_mux = port_e_direction_r;
      PEK_OFF_PORT_K_DATA:      rd_mux = k_rd;
      PEK_OFF_PORT_K_DIRECTION: rd_mux = port_k_direction_r;
      PEK_OFF_PULLUP_CONTROL:   rd_mux = pullup_control_r;
      PEK_OFF_MODE_CONTROL:     rd_mux = mode_control_r;
      PEK_OFF_BUS_IF_CONTROL:   rd_mux = bus_interface_control_r;
      default:                  rd_mux = 8'h00;
    endcase
  end

  // Registered read data; unmapped reads return zero
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= 8'h00;
    else if (sel_rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 8'h00;
  end

  // Unclaimed access goes out on the external bus
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      ext_echo_r <= 1'b0;
    else
      ext_echo_r <= (req.wr || req.rd) && !hit;
  end

  assign rdata    = rdata_r;
  assign ext_echo = ext_echo_r;

  // Chip-select gap after each bus-clock fall, except a stretched one while clock stretch select is clear
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      gap_r <= 1'b0;
    else
      gap_r <= xbus.clk_fall && !(xbus.stretched && !clock_stretch_select);
  end

  // Emulation drive for port K
  always_comb
  begin
    k_emu_o                 = 8'h00;
    k_emu_o[5:0]            = xbus.page;
    k_emu_o[PEK_CS_EXT_BIT] = !xbus.ext_sel || gap_r;
    k_emu_o[PEK_CS_EMU_BIT] = !xbus.emu_sel || gap_r;
  end

  // Port E pin drive
  always_comb
  begin
    port_e_pins.o  = port_e_data_r;
    port_e_pins.oe = port_e_direction_r & PEK_E_OUT_MASK;
    port_e_pins.pu = {8{pullup_control_r[PEK_PULLUP_CONTROL_PUPEE_BIT]}} & ~port_e_pins.oe;
  end

  // Port K pin drive: emulation or GPIO
  always_comb
  begin
    if (port_k_emulation_enable)
    begin
      port_k_pins.o  = k_emu_o;
      port_k_pins.oe = 8'hFF;
      port_k_pins.pu = 8'h00;
    end
    else
    begin
      port_k_pins.o  = port_k_data_r;
      port_k_pins.oe = port_k_direction_r;
      port_k_pins.pu = {8{pullup_control_r[PEK_PULLUP_CONTROL_PORT_K_PULLUP_ENABLE_BIT]}}
                       & ~port_k_direction_r;
    end
  end

endmodule

//--- testbench/pek_pin_model.sv
`timescale 1ns/1ps
module pek_pin_model
  import pek_pkg::*;
(
  input pek_pkg::pek_pins_s pins,
  input wire logic          far_oe,
  input wire logic [7:0]    far_v,
  output logic [7:0]        lvl
);
  // Wire level: own drive, far drive, pull-up, else a drifting float
  always_comb
  begin
    for (int b = 0; b < 8; b++)
      lvl[b] = pins.oe[b] ? pins.o[b] : far_oe ? far_v[b] : pins.pu[b] | ~far_v[b];
  end
endmodule

//--- testbench/pek_port_ek_monitor.sv
`timescale 1ns/1ps
module pek_port_ek_monitor
  import pek_pkg::*;
(
  input wire logic               mclk,
  input wire logic               arst_n,
  input pek_pkg::pek_req_s       req,
  input wire logic [7:0]         rdata,
  input wire logic               ext_echo,
  input pek_pkg::pek_chip_mode_e chip_mode,
  input pek_pkg::pek_pins_s      port_e_pins
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // Access and mode helpers
  wire acc = req.wr | req.rd;
  wire sng = chip_mode == PEK_MODE_SINGLE;
  wire a_e = req.addr == PEK_OFF_PORT_E_DIRECTION;
  a_irq_no_drive: assert property (port_e_pins.oe[1:0] == 2'h0)
    else $error("port E interrupt bits driven");
  a_e_dir_drive: assert property (req.wr && a_e && sng
    |=> port_e_pins.oe[7:2] == $past(req.wdata[7:2])) else $error("direction not applied");
  a_e_dir_read: assert property (req.rd && a_e && sng |=> rdata == $past(port_e_pins.oe))
    else $error("direction readback wrong");
  a_e_dir_hidden: assert property (acc && a_e && !sng |=> ext_echo)
    else $error("hidden access not echoed");
  a_k_data_mapped: assert property (acc && sng && req.addr == PEK_OFF_PORT_K_DATA
    |=> !ext_echo) else $error("mapped access echoed");
  a_echo_cause: assert property (ext_echo |-> $past(acc))
    else $error("echo without access");
  a_echo_no_data: assert property (ext_echo |-> rdata == 8'h00)
    else $error("echoed read returned data");
  a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_e_data_out: assert property (req.wr && sng && req.addr == PEK_OFF_PORT_E_DATA
    |=> port_e_pins.o[7:2] == $past(req.wdata[7:2])) else $error("port E latch not driven");
endmodule

//--- testbench/tb_pek_port_ek.sv
`timescale 1ns/1ps
module tb_pek_port_ek;
  import pek_pkg::*;
  logic           mclk, arst_n, ext_echo, far_oe;
  logic [7:0]     rdata, far_e, far_k, lvl_e, lvl_k, m_ed, m_edir, m_kd, m_kdir, m_pu, m_mode, m_ebi;
  pek_req_s       req;
  pek_chip_mode_e chip_mode;
  pek_xbus_s      xbus;
  pek_pins_s      pe, pk;
  int             err_total, n_compared, seed;
  logic [7:0]     adr [8] = '{8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0E, 8'h32, 8'h33, 8'h55};
  pek_port_ek uut (.mclk, .arst_n, .req, .rdata, .ext_echo, .chip_mode, .xbus,
    .port_e_pin_i(lvl_e), .port_e_pins(pe), .port_k_pin_i(lvl_k), .port_k_pins(pk));
  pek_pin_model pme (.pins(pe), .far_oe(1'b1), .far_v(far_e), .lvl(lvl_e));
  pek_pin_model pmk (.pins(pk), .far_oe(far_oe), .far_v(far_k), .lvl(lvl_k));
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic hid(input logic [7:0] a);
    return !(a inside {8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0E, 8'h32, 8'h33})
      || (a == 8'h09 && chip_mode != PEK_MODE_SINGLE)
      || (a == 8'h32 && chip_mode != PEK_MODE_SINGLE && m_mode[3]);
  endfunction
  function automatic logic [7:0] pin(input logic [7:0] dir, dat, pu, far, input logic fo);
    return (dir & dat) | (~dir & (fo ? far : pu | ~far));
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (hid(a))
      return 8'h00;
    case (a)
      8'h08: return pin(m_edir, m_ed, 8'h00, far_e, 1'b1);
      8'h09: return m_edir;
      8'h0B: return m_mode;
      8'h0C: return m_pu;
      8'h0E: return m_ebi;
      8'h32: return pin(m_kdir, m_kd, {8{m_pu[7]}}, far_k, far_oe);
      default: return m_kdir;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    if (!hid(a))
      case (a)
        8'h08: m_ed = d;
        8'h09: m_edir = d & PEK_E_OUT_MASK;
        8'h0B: m_mode = d;
        8'h0C: m_pu = d;
        8'h0E: m_ebi = d;
        8'h32: m_kd = d;
        8'h33: m_kdir = d;
      endcase
    @(posedge mclk);
    req.wr <= 1'b0; // Gap before any read
  endtask
  task automatic rc(input logic [7:0] a);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp_rd(a));
    chk({7'h00, ext_echo}, {7'h00, hid(a)});
  endtask
  task automatic test_done();
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100us;
    err_total++;
    test_done();
  end
  initial
  begin
    seed = 32'h27111668;
    {req, xbus, far_oe, far_e, far_k} = '0;
    chip_mode = PEK_MODE_SINGLE;
    {m_ed, m_edir, m_kd, m_kdir, m_mode} = '0;
    m_pu = PEK_RST_PULLUP;
    m_ebi = PEK_RST_EBI;
    arst_n = 1'b0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (adr[i]) rc(adr[i]);
    // Random GPIO traffic; data before direction
    repeat (10)
    begin
      wr(8'h08, 8'($random(seed)));
      wr(8'h09, 8'($random(seed)));
      wr(8'h32, 8'($random(seed)));
      wr(8'h33, 8'($random(seed)));
      wr(8'h0C, 8'($random(seed)) & 8'h90);
      far_e <= 8'($random(seed));
      far_k <= 8'($random(seed));
      far_oe <= 1'($random(seed));
      repeat (5) @(posedge mclk);
      #1;
      chk(pe.oe, m_edir);
      chk(pe.o, m_ed);
      chk(pe.pu, ~m_edir & {8{m_pu[4]}});
      chk(pk.oe, m_kdir);
      chk(pk.o, m_kd);
      chk(pk.pu, ~m_kdir & {8{m_pu[7]}});
      foreach (adr[i]) rc(adr[i]);
    end
    // Map removal per chip mode and emulation bits
    for (int m = 0; m < 6; m++)
    begin
      if (m == 1)
        continue;
      chip_mode <= PEK_MODE_SINGLE;
      wr(8'h0B, m[0] ? 8'h0C : 8'h00);
      chip_mode <= pek_chip_mode_e'(m / 2);
      wr(8'h09, 8'($random(seed)));
      wr(8'h32, 8'($random(seed)));
      rc(8'h09);
      rc(8'h32);
    end
    // Emulated selects and page bits
    for (int s = 0; s < 4; s++)
    begin
      chip_mode <= PEK_MODE_SINGLE;
      wr(8'h0E, {7'h00, s[1]});
      chip_mode <= PEK_MODE_EXPANDED;
      xbus <= '{1'b0, s[0], 1'b1, 1'b1, 6'($random(seed))};
      @(posedge mclk);
      xbus.clk_fall <= 1'b1;
      #1;
      chk(pk.o, {2'b00, xbus.page});
      @(posedge mclk);
      xbus.clk_fall <= 1'b0;
      #1;
      chk({6'h00, pk.o[7:6]}, {6'h00, {2{!(s[0] && !s[1])}}});
    end
    test_done();
  end
endmodule
bind pek_port_ek pek_port_ek_monitor mon (.mclk, .arst_n, .req, .rdata, .ext_echo, .chip_mode,
  .port_e_pins);
